// *** ars_sequencer.sv ***
// Round-robin sequencer for a 10-bit converter with APB register access.
// Assumes the converter core runs on clk: start is a one-cycle pulse,
// done is a one-cycle pulse with code and gain valid beside it.
`timescale 1ns/1ps
`default_nettype none
module ars_sequencer
  import ars_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output ars_req_type      convReq,
  input  wire ars_rsp_type convRsp,
  output logic             supplyPathEn,
  output logic             backupPathEn,
  output logic             chipIrqOut
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [4:0]        ctrl;
  logic [2:0]        aux;
  logic              roundFlag;
  logic              roundMask;
  logic              topFlag;
  logic              topMask;
  logic [7:0]        selTab [DEPTH];
  logic [RES_W-1:0]  resTab [DEPTH];
  ars_state_type     state;
  logic [IDX_W-1:0]  idx;
  logic [TICK_W-1:0] cycCnt;
  logic [4:0]        msCnt;

  logic [4:0]        next_ctrl;
  logic [2:0]        next_aux;
  logic              next_roundFlag;
  logic              next_roundMask;
  logic              next_topFlag;
  logic              next_topMask;
  logic [7:0]        next_selTab [DEPTH];
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_chipIrqOut;
  logic [RES_W-1:0]  next_resTab [DEPTH];
  ars_state_type     next_state;
  logic [IDX_W-1:0]  next_idx;
  logic [TICK_W-1:0] next_cycCnt;
  logic [4:0]        next_msCnt;
  ars_req_type       next_convReq;

  logic              access;
  logic              selHit;
  logic              resHit;
  logic              regHit;
  logic [IDX_W-1:0]  tIdx;
  logic              runOk;
  logic              roundEvt;
  logic [7:0]        entry;

  assign supplyPathEn = aux[AUX_SUPPLY];
  assign backupPathEn = aux[AUX_BACKUP];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: pready rises the cycle after the access phase starts
  assign access = psel & penable & ~pready;
  assign tIdx   = paddr[6:2];
  // A misaligned table address hits nothing, so it is refused whole:
  // no table write, and the read word stays zero beside pslverr
  assign selHit = (paddr[11:7] == SEL_REGION) & (paddr[1:0] == 2'h0);
  assign resHit = (paddr[11:7] == RES_REGION) & (paddr[1:0] == 2'h0);
  assign regHit = (paddr == OFS_CTRL1) | (paddr == OFS_AUX) |
                  (paddr == OFS_CSTAT) | (paddr == OFS_CMASK) |
                  (paddr == OFS_TSTAT) | (paddr == OFS_TMASK);

  // ----------------------------------------------------------------
  // Register group
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl      = ctrl;
    next_aux       = aux;
    next_roundFlag = roundFlag;
    next_roundMask = roundMask;
    next_topFlag   = topFlag;
    next_topMask   = topMask;
    next_selTab    = selTab;
    next_prdata    = prdata;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    if (access) begin
      next_pready  = 1'b1;
      next_prdata  = 32'h0000_0000;
      next_pslverr = ~(selHit | resHit | regHit) | (paddr[1:0] != 2'h0);
      if (pwrite) begin
        if (selHit) begin
          next_selTab[tIdx] = pwdata[7:0];
        end
        unique case (paddr)
          OFS_CTRL1: next_ctrl = pwdata[4:0];
          OFS_AUX:   next_aux = pwdata[2:0];
          OFS_CSTAT: next_roundFlag = roundFlag & ~pwdata[RND_BIT];
          OFS_CMASK: next_roundMask = pwdata[RND_BIT];
          OFS_TSTAT: next_topFlag = topFlag & ~pwdata[TOP_ADC_BIT];
          OFS_TMASK: next_topMask = pwdata[TOP_ADC_BIT];
          default:   next_ctrl = ctrl;
        endcase
      end else begin
        if (selHit) begin
          next_prdata[7:0] = selTab[tIdx];
        end
        if (resHit) begin
          // Valid once the round-done flag is up
          next_prdata[RES_W-1:0] = resTab[tIdx];
        end
        unique case (paddr)
          OFS_CTRL1: next_prdata[4:0] = ctrl;
          OFS_AUX:   next_prdata[2:0] = aux;
          OFS_CSTAT: next_prdata[RND_BIT] = roundFlag;
          OFS_CMASK: next_prdata[RND_BIT] = roundMask;
          OFS_TSTAT: next_prdata[TOP_ADC_BIT] = topFlag;
          OFS_TMASK: next_prdata[TOP_ADC_BIT] = topMask;
          default:   next_prdata[31] = 1'b0;
        endcase
      end
    end
    // Applied after the bus clear so a same-cycle event wins
    if (roundEvt) begin
      next_roundFlag = 1'b1;
      if (!roundMask) begin
        next_topFlag = 1'b1;
      end
    end
    next_chipIrqOut = next_topFlag & ~next_topMask;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl       <= RST_CTRL1;
      aux        <= RST_AUX;
      roundFlag  <= 1'b0;
      roundMask  <= RST_MASK;
      topFlag    <= 1'b0;
      topMask    <= RST_MASK;
      selTab     <= '{default: 8'h00};
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      chipIrqOut <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      aux        <= next_aux;
      roundFlag  <= next_roundFlag;
      roundMask  <= next_roundMask;
      topFlag    <= next_topFlag;
      topMask    <= next_topMask;
      selTab     <= next_selTab;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      chipIrqOut <= next_chipIrqOut;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer group
  // ----------------------------------------------------------------
  // Enable gates start: nothing runs until both are set
  assign runOk = ctrl[CTL_EN] & ctrl[CTL_GO];
  assign entry = selTab[idx];

  always_comb begin
    next_state         = state;
    next_idx           = idx;
    next_cycCnt        = cycCnt;
    next_msCnt         = msCnt;
    next_resTab        = resTab;
    next_convReq       = convReq;
    next_convReq.start = 1'b0;
    roundEvt           = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_convReq.bias = 3'h0;
        if (runOk) begin
          next_idx   = '0;
          next_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (!runOk) begin
          next_state = ST_IDLE;
        end else if (entry[4:0] == STOP_CODE) begin
          roundEvt   = 1'b1;
          next_state = ST_SLEEP;
        end else if ((entry[4:0] == CH_SUPPLY && !aux[AUX_SUPPLY]) ||
                     (entry[4:0] == CH_BACKUP && !aux[AUX_BACKUP])) begin
          // Supply or backup channel with its path bit clear: skipped with a zero result
          next_resTab[idx] = '0;
          next_idx         = idx + 5'h01;
          if (idx == 5'h1F) begin
            roundEvt   = 1'b1;
            next_state = ST_SLEEP;
          end
        end else begin
          next_convReq.bias  = entry[7:5];
          next_convReq.chan  = entry[4:0];
          next_convReq.start = 1'b1;
          next_state         = ST_WAIT;
        end
        next_cycCnt = '0;
        next_msCnt  = 5'h00;
      end
      ST_WAIT: begin
        if (!runOk) begin
          next_convReq.bias = 3'h0;
          next_state        = ST_IDLE;
        end else if (convRsp.done) begin
          // Full-scale code is 2.40 V on any channel
          next_resTab[idx] = {convRsp.gain,
                              aux[AUX_SCALE] ? ars_scale(convReq.chan, convRsp.code)
                                             : convRsp.code};
          next_idx         = idx + 5'h01;
          next_state       = ST_ISSUE;
          if (idx == 5'h1F) begin
            // All 32 filled without a stop entry still closes the round
            roundEvt          = 1'b1;
            next_convReq.bias = 3'h0;
            next_state        = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        next_convReq.bias = 3'h0;
        if (!runOk) begin
          next_state = ST_IDLE;
        end else if (msCnt >= ars_sleep_ms(ctrl[CTL_SLP +: 3])) begin
          next_idx   = '0;
          next_state = ST_ISSUE;
        end else if (cycCnt == TICK_W'(MS_CYC - 1)) begin
          next_cycCnt = '0;
          next_msCnt  = msCnt + 5'h01;
        end else begin
          next_cycCnt = cycCnt + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state   <= ST_IDLE;
      idx     <= '0;
      cycCnt  <= '0;
      msCnt   <= 5'h00;
      resTab  <= '{default: 11'h000};
      convReq <= '0;
    end else begin
      state   <= next_state;
      idx     <= next_idx;
      cycCnt  <= next_cycCnt;
      msCnt   <= next_msCnt;
      resTab  <= next_resTab;
      convReq <= next_convReq;
    end
  end
  // Round time is 32 converter turnarounds plus 33 cycles
  // it holds as long as the core answers within about 488 us per sample.
endmodule
`default_nettype wire

// *** ars_pkg.sv ***
// Constants, carriers and helpers for the converter round sequencer.
// Assumes one 100 MHz clock shared with the APB master and converter core.
package ars_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DEPTH  = 32;
  localparam int IDX_W  = 5;
  localparam int CODE_W = 10;
  localparam int RES_W  = CODE_W + 1;
  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL1 = 12'h000;
  localparam logic [11:0] OFS_AUX   = 12'h004;
  localparam logic [11:0] OFS_CSTAT = 12'h008;
  localparam logic [11:0] OFS_CMASK = 12'h00C;
  localparam logic [11:0] OFS_TSTAT = 12'h010;
  localparam logic [11:0] OFS_TMASK = 12'h014;
  localparam logic [4:0]  SEL_REGION = 5'h01;
  localparam logic [4:0]  RES_REGION = 5'h02;
  localparam int CTL_EN      = 0;
  localparam int CTL_GO      = 1;
  localparam int CTL_SLP     = 2;
  localparam int AUX_SCALE   = 0;
  localparam int AUX_SUPPLY  = 1;
  localparam int AUX_BACKUP  = 2;
  localparam int RND_BIT     = 0;
  localparam int TOP_ADC_BIT = 1;
  localparam logic [4:0] RST_CTRL1 = 5'h00;
  localparam logic [2:0] RST_AUX   = 3'h0;
  localparam logic       RST_MASK  = 1'h0;
  // ----------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------
  localparam logic [4:0] STOP_CODE = 5'h1F;
  localparam logic [4:0] CH_SUPPLY = 5'h16;
  localparam logic [4:0] CH_BACKUP = 5'h19;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W         = 17;
  localparam int ROUND_LIMIT_US = 15625;
  // Scale factors in 1/1024 of one engineering step per raw step
  localparam logic [9:0] K_TEMP = 10'h1B3;
  localparam logic [9:0] K_VCC  = 10'h1A4;
  localparam logic [9:0] K_VNN  = 10'h0BE;
  localparam logic [9:0] K_V180 = 10'h032;
  localparam logic [9:0] K_VBAT = 10'h1E0;
  localparam logic [9:0] K_THRM = 10'h0F0;
  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bias;
    logic [4:0] chan;
    logic       start;
  } ars_req_type;
  typedef struct packed {
    logic              done;
    logic              gain;
    logic [CODE_W-1:0] code;
  } ars_rsp_type;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_SLEEP = 2'b11
  } ars_state_type;

  function automatic logic [4:0] ars_sleep_ms(input logic [2:0] sel);
    logic [4:0] ms;
    unique case (sel)
      3'h0: ms = 5'h00;
      3'h1: ms = 5'h01;
      3'h2: ms = 5'h02;
      3'h3: ms = 5'h04;
      3'h4: ms = 5'h08;
      3'h5: ms = 5'h10;
      3'h6: ms = 5'h18;
      3'h7: ms = 5'h1B;
    endcase
    return ms;
  endfunction

  // Slope only: the temperature offset is left to software
  function automatic logic [9:0] ars_scale(input logic [4:0] chan, input logic [9:0] code);
    logic [9:0]  k;
    logic [19:0] p;
    case (chan)
      5'h00:   k = K_TEMP;
      5'h01:   k = K_VCC;
      5'h02:   k = K_VNN;
      5'h03:   k = K_V180;
      5'h06:   k = K_VBAT;
      5'h09:   k = K_THRM;
      default: k = 10'h000;
    endcase
    p = code * k;
    return (k == 10'h000) ? code : p[19:10];
  endfunction
endpackage

// *** ars_seq_properties.sv ***
// Concurrent checks on the round sequencer ports, bound to every instance.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ars_seq_properties
  import ars_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire ars_req_type convReq,
  input wire ars_rsp_type convRsp,
  input wire logic        supplyPathEn,
  input wire logic        backupPathEn,
  input wire logic        chipIrqOut
);
  // ----------------------------------------------------------------
  // Shadow of enable and start, as software last wrote them
  // ----------------------------------------------------------------
  logic run;
  logic next_run;
  logic wrAcc;
  assign wrAcc = psel && penable && pready && pwrite;
  always_comb begin
    next_run = run;
    if (wrAcc && paddr == OFS_CTRL1) begin
      next_run = pwdata[CTL_EN] & pwdata[CTL_GO];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run <= 1'b0;
    end else begin
      run <= next_run;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_apbAnswer; psel && penable && !pready |=> pready; endproperty
  property p_errZero; pready && pslverr |-> prdata == 32'h0; endproperty
  property p_startPulse; convReq.start |=> !convReq.start; endproperty
  property p_noStopConv; convReq.start |-> convReq.chan != STOP_CODE; endproperty
  property p_idleNoStart; !run |-> !convReq.start; endproperty
  property p_biasIdle; !run |=> convReq.bias == 3'h0; endproperty
  property p_holdSel;
    convReq.start && next_run |=> $stable(convReq.chan) && $stable(convReq.bias);
  endproperty
  property p_supplyEn;
    wrAcc && paddr == OFS_AUX |=> supplyPathEn == $past(pwdata[AUX_SUPPLY]);
  endproperty
  property p_backupEn;
    wrAcc && paddr == OFS_AUX |=> backupPathEn == $past(pwdata[AUX_BACKUP]);
  endproperty
  a_apbAnswer: assert property (p_apbAnswer)
    else $error("register access not answered after one wait state");
  a_errZero: assert property (p_errZero)
    else $error("refused access returned nonzero read data");
  a_startPulse: assert property (p_startPulse)
    else $error("conversion start longer than one cycle");
  a_noStopConv: assert property (p_noStopConv)
    else $error("conversion started on the stop code");
  a_idleNoStart: assert property (p_idleNoStart)
    else $error("conversion started while disabled or not started");
  a_biasIdle: assert property (p_biasIdle)
    else $error("bias switches left on while idle");
  a_holdSel: assert property (p_holdSel)
    else $error("channel or bias moved during a conversion");
  a_supplyEn: assert property (p_supplyEn)
    else $error("supply path enable does not follow its bit");
  a_backupEn: assert property (p_backupEn)
    else $error("backup path enable does not follow its bit");
  c_start: cover property (convReq.start);
  c_irq: cover property ($rose(chipIrqOut));
  c_err: cover property (pready && pslverr);
endmodule
bind ars_sequencer ars_seq_properties #(.MS_CYC(MS_CYC)) u_props (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .convReq(convReq), .convRsp(convRsp),
  .supplyPathEn(supplyPathEn), .backupPathEn(backupPathEn), .chipIrqOut(chipIrqOut)
);
`default_nettype wire

// *** ars_conv_model.sv ***
// Behavioural converter core facing the sequencer.
// Assumes start pulses on clk; answers DLY+1 cycles later with a code made
// from bias and channel so the bench can predict every result.
`timescale 1ns/1ps
`default_nettype none
module ars_conv_model
  import ars_pkg::*;
#(
  parameter int DLY = 3
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire ars_req_type convReq,
  output ars_rsp_type      convRsp
);
  int          cnt;
  int          next_cnt;
  ars_rsp_type next_convRsp;
  always_comb begin
    next_cnt = (cnt > 0) ? cnt - 1 : 0;
    // Outside done the data lines toggle, so a stale capture shows up
    next_convRsp = '{done: 1'b0, gain: ~convRsp.gain, code: ~convRsp.code};
    if (convReq.start) begin
      next_cnt = DLY;
    end
    if (cnt == 1) begin
      next_convRsp = '{done: 1'b1, gain: convReq.chan[0],
                       code: {convReq.bias, convReq.chan, 2'b01}};
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt     <= 0;
      convRsp <= '0;
    end else begin
      cnt     <= next_cnt;
      convRsp <= next_convRsp;
    end
  end
endmodule
`default_nettype wire

// *** test_adc_round_robin_sequencer.sv ***
// Self-checking bench for the round sequencer with a converter model.
// Assumes MS_CYC of 10 so one millisecond of sleep is ten cycles.
`timescale 1ns/1ps
`default_nettype none
module test_adc_round_robin_sequencer
  import ars_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r;
    logic        e;
  } ars_row_type;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        supplyPathEn;
  logic        backupPathEn;
  logic        chipIrqOut;
  ars_req_type convReq;
  ars_rsp_type convRsp;
  logic [31:0] rd;
  logic        e;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          st[$];
  logic [4:0]  ch[$];
  logic [7:0]  tbl [4] = '{8'hAB, 8'h06, 8'h16, 8'h1F};
  ars_row_type rows [10] = '{
    '{OFS_AUX, 32'h7, 32'h7, 1'b0}, '{OFS_AUX, 32'h0, 32'h0, 1'b0},
    '{OFS_CMASK, 32'hFFFFFFFF, 32'h1, 1'b0}, '{OFS_CMASK, 32'h0, 32'h0, 1'b0},
    '{OFS_TMASK, 32'hFFFFFFFF, 32'h2, 1'b0}, '{OFS_TMASK, 32'h0, 32'h0, 1'b0},
    '{12'h084, 32'hFFFFFFAB, 32'hAB, 1'b0}, '{12'h17C, 32'h5, 32'h0, 1'b0},
    '{12'h300, 32'h1, 32'h0, 1'b1}, '{12'h002, 32'h1, 32'h0, 1'b1}};
  ars_sequencer #(.MS_CYC(10)) DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .convReq(convReq),
    .convRsp(convRsp), .supplyPathEn(supplyPathEn), .backupPathEn(backupPathEn),
    .chipIrqOut(chipIrqOut));
  ars_conv_model #(.DLY(3)) u_conv (.clk(clk), .sys_rst(sys_rst), .convReq(convReq),
    .convRsp(convRsp));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (convReq.start === 1'b1) begin
      st.push_back(cyc);
      ch.push_back(convReq.chan);
    end
  end
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic pollFlag();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_CSTAT, 32'h0);
      n++;
    end while (rd[RND_BIT] !== 1'b1 && n < 200);
    chk(rd, 32'h1);
  endtask
  function automatic logic [31:0] res(input logic [7:0] s, input logic sc);
    logic [19:0] c;
    c = {10'h0, s, 2'b01};
    if (sc && s[4:0] == 5'h06) c = (c * K_VBAT) >> 10;
    return {21'h0, s[0], c[9:0]};
  endfunction
  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rdc(12'(4 * i), 32'h0, 1'b0);
    chk({supplyPathEn, backupPathEn, chipIrqOut, convReq.start}, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].r, rows[i].e);
    end
    $display("register table done");
    for (int i = 0; i < 4; i++) apb(1'b1, 12'h080 + 12'(4 * i), {24'h0, tbl[i]});
    apb(1'b1, OFS_CTRL1, 32'h17);
    pollFlag();
    chk({31'h0, chipIrqOut}, 32'h1);
    rdc(OFS_TSTAT, 32'h2, 1'b0);
    for (int i = 0; i < 3; i++) rdc(12'h100 + 12'(4 * i), (i == 2) ? 32'h0 : res(tbl[i], 1'b0), 1'b0);
    apb(1'b1, OFS_CSTAT, 32'h1);
    apb(1'b1, OFS_TSTAT, 32'h2);
    chk({31'h0, chipIrqOut}, 32'h0);
    pollFlag();
    chk({ch[0], ch[1], ch[2]}, {5'h0B, 5'h06, 5'h0B});
    chk(32'(st[2] - st[1] >= 160 && st[2] - st[1] < 190), 32'h1);
    $display("first rounds done");
    apb(1'b1, OFS_TMASK, 32'h2);
    apb(1'b1, OFS_AUX, 32'h3);
    apb(1'b1, OFS_CSTAT, 32'h1);
    apb(1'b1, OFS_TSTAT, 32'h2);
    pollFlag();
    chk({31'h0, chipIrqOut}, 32'h0);
    rdc(12'h104, res(tbl[1], 1'b1), 1'b0);
    rdc(12'h108, res(tbl[2], 1'b0), 1'b0);
    apb(1'b1, OFS_TMASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, chipIrqOut}, 32'h1);
    apb(1'b1, OFS_CMASK, 32'h1);
    apb(1'b1, OFS_CSTAT, 32'h1);
    apb(1'b1, OFS_TSTAT, 32'h2);
    pollFlag();
    rdc(OFS_TSTAT, 32'h0, 1'b0);
    $display("mask and scale done");
    apb(1'b1, OFS_CTRL1, 32'h2);
    begin
      int n;
      n = st.size();
      repeat (300) @(posedge clk);
      chk(32'(st.size()), 32'(n));
    end
    $display("disable done");
    complete_run();
  end
endmodule
`default_nettype wire
